// ### host_command_mailbox.sv
// host-side controller that issues and collects mailbox commands
//
// What this block does
// - input type in low two bits: 00 descriptor, 01 control, 11 line init
// - host writes type and direction, then sets request bit 5; the code writes type, direction and request bit 5 in one write
// - device grants port by setting ready; host writes port only after seeing it
// - host writes all port bytes and zeroes unused ones
// - host clears request after loading port; clearing triggers execution
// - no host writes after clear until device drops input ready
// - device sets output request; host clears it when done with registers
// - host clears output ready to signal completion
// - entry word 0 address low, word 2 address 16-17 and end flag
// - entry word 4 holds length in words, odd byte rounded up
// - host zeroes status word; device writes 1, 2, -4 or -5
// - list ends at a word with bit 0 set
// - host rechecks interrupt enable, which device may clear briefly
`timescale 1ns/100ps
`default_nettype none

module host_command_mailbox
  import host_mailbox_pkg::*;
#(
  parameter int unsigned GRANT_WAIT_CYC = GRANT_MAX_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // apb slave for software
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // apb master to the device registers
  output logic [2:0] dev_paddr_o,
  output logic dev_psel_o,
  output logic dev_penable_o,
  output logic dev_pwrite_o,
  output logic [15:0] dev_pwdata_o,
  output logic [1:0] dev_pstrb_o,
  input wire logic [15:0] dev_prdata_i,
  input wire logic dev_pready_i
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mbox_state_type state_q, state_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [1:0] type_q, type_d;
  logic dir_q, dir_d, ie_q, ie_d, oie_q, oie_d, go_q, go_d;
  logic [7:0] b3_q, b3_d;
  logic [31:0] pw_q, pw_d;
  logic done_q, done_d, tmo_q, tmo_d, ov_q, ov_d;
  logic [15:0] oc_q, oc_d;
  logic [31:0] ow_q, ow_d;
  logic [31:0] prdata_d;
  logic pslverr_d, pready_q;
  logic [2:0] addr_d;
  logic psel_d, pen_d, pwr_d;
  logic [15:0] wdat_d;
  logic [1:0] strb_d;
  logic xfer_done, busy, done_set, tmo_set, ov_set, go_take;
  logic [7:0] ctl_byte;

  assign xfer_done = dev_psel_o & dev_penable_o & dev_pready_i;
  assign busy = go_q | (state_q inside {S_CHK_FREE, S_WR_REQ, S_POLL_GRANT, S_WR_B3,
                                        S_WR_W4, S_WR_W6, S_WR_CLR, S_POLL_DONE});
  // input control byte image; request bit is added when asking
  assign ctl_byte = {1'b0, ie_q, 2'h0, dir_q, 1'b0, type_q};

  // ----------------------------------------------------------------
  // command sequencer and device bus master
  // ----------------------------------------------------------------
  // one device access per state other than S_IDLE; each access is setup then access until ready
  always_comb begin
    state_d = state_q;
    tmr_d = (state_q == S_POLL_GRANT) ? tmr_q + 1'b1 : '0;
    psel_d = dev_psel_o;
    pen_d = dev_penable_o;
    addr_d = dev_paddr_o;
    pwr_d = dev_pwrite_o;
    wdat_d = dev_pwdata_o;
    strb_d = dev_pstrb_o;
    oc_d = oc_q;
    ow_d = ow_q;
    done_set = 1'b0;
    tmo_set = 1'b0;
    ov_set = 1'b0;
    go_take = 1'b0;
    if (state_q == S_IDLE) begin
      // inbound commands first; otherwise keep polling the output byte
      state_d = go_q ? S_CHK_FREE : S_OUT_RD2;
    end else if (!dev_psel_o) begin
      psel_d = 1'b1;
      pen_d = 1'b0;
      pwr_d = 1'b1;
      strb_d = STRB_LO;
      wdat_d = '0;
      addr_d = DEV_IN_CTL;
      unique case (state_q)
        S_WR_REQ: wdat_d = {8'h00, ctl_byte | 8'(1 << IN_REQ_BIT)};
        S_WR_B3: begin
          addr_d = DEV_OUT_CTL;
          strb_d = STRB_HI;
          wdat_d = {b3_q, 8'h00};
        end
        S_WR_W4: begin
          addr_d = DEV_PORT_W4;
          strb_d = STRB_WORD;
          wdat_d = pw_q[15:0];
        end
        S_WR_W6: begin
          addr_d = DEV_PORT_W6;
          strb_d = STRB_WORD;
          wdat_d = pw_q[31:16];
        end
        S_WR_CLR: wdat_d = {8'h00, ctl_byte};
        S_OUT_ACK: begin
          // ready and request dropped together, enable written from oie_q
          addr_d = DEV_OUT_CTL;
          wdat_d = {8'h00, 8'(oie_q) << OUT_IE_BIT};
        end
        S_OUT_RD2: begin
          pwr_d = 1'b0;
          addr_d = DEV_OUT_CTL;
          strb_d = '0;
        end
        S_OUT_RD4: begin
          pwr_d = 1'b0;
          addr_d = DEV_PORT_W4;
          strb_d = '0;
        end
        S_OUT_RD6: begin
          pwr_d = 1'b0;
          addr_d = DEV_PORT_W6;
          strb_d = '0;
        end
        default: begin
          // the polls read the input control byte as a word
          pwr_d = 1'b0;
          strb_d = '0;
        end
      endcase
    end else if (!dev_penable_o) begin
      pen_d = 1'b1;
    end else if (dev_pready_i) begin
      psel_d = 1'b0;
      pen_d = 1'b0;
      unique case (state_q)
        S_CHK_FREE: begin
          // a command may only start once the last grant has dropped
          if (!dev_prdata_i[IN_GRANT_BIT]) begin
            state_d = S_WR_REQ;
            go_take = 1'b1;
          end else begin
            state_d = S_IDLE;
          end
        end
        S_WR_REQ: state_d = S_POLL_GRANT;
        S_POLL_GRANT: begin
          if (dev_prdata_i[IN_GRANT_BIT]) begin
            state_d = S_WR_B3;
          end else if (tmr_q >= TMR_W'(GRANT_WAIT_CYC)) begin
            // grant overdue: give up and report, request stays with device
            state_d = S_IDLE;
            tmo_set = 1'b1;
          end else if (ie_q && !dev_prdata_i[IN_IE_BIT]) begin
            // enable lost in the device's clearing window: write it again
            state_d = S_WR_REQ;
          end
        end
        S_WR_B3: state_d = S_WR_W4;
        S_WR_W4: state_d = S_WR_W6;
        S_WR_W6: state_d = S_WR_CLR;
        S_WR_CLR: state_d = S_POLL_DONE;
        S_POLL_DONE: begin
          // no further writes until the device ends the input cycle
          if (!dev_prdata_i[IN_GRANT_BIT]) begin
            state_d = S_IDLE;
            done_set = 1'b1;
          end
        end
        S_OUT_RD2: begin
          // an earlier command whose status bit 2 is not yet cleared holds the device off
          if (dev_prdata_i[OUT_READY_BIT] && !ov_q) begin
            oc_d = dev_prdata_i;
            state_d = S_OUT_RD4;
          end else begin
            state_d = S_IDLE;
          end
        end
        S_OUT_RD4: begin
          ow_d[15:0] = dev_prdata_i;
          state_d = S_OUT_RD6;
        end
        S_OUT_RD6: begin
          ow_d[31:16] = dev_prdata_i;
          state_d = S_OUT_ACK;
        end
        S_OUT_ACK: begin
          state_d = S_IDLE;
          ov_set = 1'b1;
        end
        default: state_d = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= S_IDLE;
      tmr_q <= '0;
      dev_psel_o <= 1'b0;
      dev_penable_o <= 1'b0;
      dev_paddr_o <= '0;
      dev_pwrite_o <= 1'b0;
      dev_pwdata_o <= '0;
      dev_pstrb_o <= '0;
      oc_q <= '0;
      ow_q <= '0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      dev_psel_o <= psel_d;
      dev_penable_o <= pen_d;
      dev_paddr_o <= addr_d;
      dev_pwrite_o <= pwr_d;
      dev_pwdata_o <= wdat_d;
      dev_pstrb_o <= strb_d;
      oc_q <= oc_d;
      ow_q <= ow_d;
    end
  end

  // ----------------------------------------------------------------
  // software register file
  // ----------------------------------------------------------------
  // writes land in the access phase; read data is caught in setup so that
  // the zero-wait answer is already stable when pready is seen
  always_comb begin
    logic wr, clr_w;
    wr = psel_i & penable_i & pwrite_i;
    clr_w = wr & (paddr_i == REG_STATUS);
    type_d = type_q;
    dir_d = dir_q;
    ie_d = ie_q;
    oie_d = oie_q;
    b3_d = b3_q;
    pw_d = pw_q;
    go_d = go_q & ~go_take;
    // command fields are frozen while a command is in flight
    if (wr && !busy) begin
      unique case (paddr_i)
        REG_CTRL: begin
          type_d = pwdata_i[1:0];
          dir_d = pwdata_i[DIR_BIT];
          ie_d = pwdata_i[3];
          oie_d = pwdata_i[4];
          go_d = pwdata_i[CTRL_GO_BIT];
        end
        REG_PORT_B3: b3_d = pwdata_i[7:0];
        REG_PORT_W: pw_d = pwdata_i;
        default: ;
      endcase
    end
    // hardware sets win over a simultaneous write-one-to-clear
    done_d = done_set | (done_q & ~(clr_w & pwdata_i[0]));
    tmo_d = tmo_set | (tmo_q & ~(clr_w & pwdata_i[1]));
    ov_d = ov_set | (ov_q & ~(clr_w & pwdata_i[2]));
    prdata_d = prdata_o;
    pslverr_d = 1'b0;
    if (psel_i && !penable_i) begin
      prdata_d = '0;
      unique case (paddr_i)
        REG_CTRL: prdata_d = {23'h0, busy, 3'h0, oie_q, ie_q, dir_q, type_q};
        REG_PORT_B3: prdata_d = {24'h0, b3_q};
        REG_PORT_W: prdata_d = pw_q;
        REG_STATUS: prdata_d = {29'h0, ov_q, tmo_q, done_q};
        REG_OUT_CMD: prdata_d = {16'h0, oc_q};
        REG_OUT_W: prdata_d = ow_q;
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      type_q <= CMD_BD_IN;
      dir_q <= 1'b0;
      ie_q <= 1'b0;
      oie_q <= 1'b0;
      go_q <= 1'b0;
      b3_q <= '0;
      pw_q <= '0;
      done_q <= 1'b0;
      tmo_q <= 1'b0;
      ov_q <= 1'b0;
      prdata_o <= '0;
      pslverr_o <= 1'b0;
      pready_q <= 1'b0;
    end else begin
      type_q <= type_d;
      dir_q <= dir_d;
      ie_q <= ie_d;
      oie_q <= oie_d;
      go_q <= go_d;
      b3_q <= b3_d;
      pw_q <= pw_d;
      done_q <= done_d;
      tmo_q <= tmo_d;
      ov_q <= ov_d;
      prdata_o <= prdata_d;
      pslverr_o <= pslverr_d;
      pready_q <= 1'b1;
    end
  end

  assign pready_o = pready_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic grant_seen_q, wait_drop_q;
  logic [1:0] port_wr_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      grant_seen_q <= 1'b0;
      wait_drop_q <= 1'b0;
      port_wr_q <= '0;
    end else begin
      if (state_q == S_IDLE) grant_seen_q <= 1'b0;
      else if (xfer_done && state_q == S_POLL_GRANT && dev_prdata_i[IN_GRANT_BIT])
        grant_seen_q <= 1'b1;
      if (state_q == S_WR_REQ) port_wr_q <= '0;
      else if (xfer_done && state_q inside {S_WR_B3, S_WR_W4, S_WR_W6})
        port_wr_q <= port_wr_q + 2'h1;
      if (xfer_done && state_q == S_WR_CLR) wait_drop_q <= 1'b1;
      else if (state_q == S_IDLE) wait_drop_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_req_bit;
    dev_psel_o && dev_pwrite_o && state_q == S_WR_REQ |->
      dev_pwdata_o[IN_REQ_BIT] && dev_pwdata_o[1:0] == type_q && dev_paddr_o == DEV_IN_CTL;
  endproperty
  a_req_bit: assert property (p_req_bit) else $error("request write malformed");
  property p_port_after_grant;
    dev_psel_o && dev_pwrite_o && (dev_pstrb_o[1] || dev_paddr_o[2]) |-> grant_seen_q;
  endproperty
  a_port_after_grant: assert property (p_port_after_grant)
    else $error("port written before grant");
  property p_clear_last;
    dev_psel_o && dev_pwrite_o && dev_paddr_o == DEV_IN_CTL && !dev_pwdata_o[IN_REQ_BIT]
      |-> port_wr_q == 2'h3;
  endproperty
  a_clear_last: assert property (p_clear_last) else $error("request cleared early");
  property p_quiet;
    dev_psel_o && dev_pwrite_o |-> !wait_drop_q;
  endproperty
  a_quiet: assert property (p_quiet) else $error("write while awaiting ready drop");
  property p_hold;
    dev_psel_o && dev_penable_o && !dev_pready_i |=>
      dev_psel_o && dev_penable_o && $stable(dev_paddr_o) && $stable(dev_pwdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("device request not held");
  property p_setup;
    dev_psel_o && !dev_penable_o |=> dev_psel_o && dev_penable_o;
  endproperty
  a_setup: assert property (p_setup) else $error("setup not followed by access");
  property p_out_ack;
    xfer_done && state_q == S_OUT_ACK |->
      !dev_pwdata_o[OUT_READY_BIT] && !dev_pwdata_o[OUT_REQ_BIT] ##1 ov_q;
  endproperty
  a_out_ack: assert property (p_out_ack) else $error("output ack wrong");
  property p_timeout;
    xfer_done && state_q == S_POLL_GRANT && !dev_prdata_i[IN_GRANT_BIT] &&
      tmr_q >= TMR_W'(GRANT_WAIT_CYC) |=> tmo_q && state_q == S_IDLE;
  endproperty
  a_timeout: assert property (p_timeout) else $error("grant timeout missed");
  property p_ie_fix;
    xfer_done && state_q == S_POLL_GRANT && !dev_prdata_i[IN_GRANT_BIT] && ie_q &&
      !dev_prdata_i[IN_IE_BIT] && tmr_q < TMR_W'(GRANT_WAIT_CYC) |=> state_q == S_WR_REQ;
  endproperty
  a_ie_fix: assert property (p_ie_fix) else $error("lost enable not restored");
  c_in_done: cover property (xfer_done && state_q == S_POLL_DONE ##1 done_q);
  c_out_cmd: cover property (ov_set);
  c_ie_retry: cover property (state_q == S_POLL_GRANT ##1 state_q == S_WR_REQ);

endmodule

`default_nettype wire

// ### host_mailbox_pkg.sv
// constants shared by the host-side command mailbox controller
package host_mailbox_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned GRANT_MAX_US = 5000; // longest wait for the grant
  // longest time rounds down to whole cycles
  localparam int unsigned GRANT_MAX_CYC = (CLK_HZ / 1_000_000) * GRANT_MAX_US;
  localparam int unsigned TMR_W = 20;

  // ----------------------------------------------------------------
  // device register byte addresses (16-bit words at even bytes)
  // ----------------------------------------------------------------
  localparam logic [2:0] DEV_IN_CTL = 3'h0;  // input_control_byte
  localparam logic [2:0] DEV_OUT_CTL = 3'h2; // output_control_byte, port byte 3 above
  localparam logic [2:0] DEV_PORT_W4 = 3'h4;
  localparam logic [2:0] DEV_PORT_W6 = 3'h6;
  localparam logic [1:0] STRB_LO = 2'h1;
  localparam logic [1:0] STRB_HI = 2'h2;
  localparam logic [1:0] STRB_WORD = 2'h3;

  // ----------------------------------------------------------------
  // control byte fields
  // ----------------------------------------------------------------
  localparam int IN_GRANT_BIT = 7;  // input_grant_flag
  localparam int IN_IE_BIT = 6;     // input_interrupt_enable
  localparam int IN_REQ_BIT = 5;    // input_request_flag
  localparam int DIR_BIT = 2;
  localparam int OUT_READY_BIT = 7; // output_ready_flag
  localparam int OUT_IE_BIT = 6;
  localparam int OUT_REQ_BIT = 5;   // output_request_flag
  localparam logic [1:0] CMD_BD_IN = 2'h0;
  localparam logic [1:0] CMD_CTL_IN = 2'h1;
  localparam logic [1:0] CMD_LINE_INIT = 2'h3;
  localparam logic [1:0] CMD_BD_OUT = 2'h0;
  localparam logic [1:0] CMD_CTL_OUT = 2'h1;
  localparam logic [1:0] CMD_BUF_OUT = 2'h2;

  // ----------------------------------------------------------------
  // descriptor list entry layout kept in host memory
  // ----------------------------------------------------------------
  // word 2 adds address bits 16-17 and the end flag; length counts words, odd byte up;
  // the status word is zeroed before hand-over
  localparam logic [2:0] DESC_ADDR_LO = 3'h0;
  localparam logic [2:0] DESC_ADDR_HI = 3'h2;
  localparam logic [2:0] DESC_WCOUNT = 3'h4;
  localparam logic [2:0] DESC_STATUS = 3'h6;
  localparam logic [15:0] DST_COUNT_DONE = 16'h0001;
  localparam logic [15:0] DST_RX_EOM = 16'h0002;
  localparam logic [15:0] DST_READY_ERR = 16'hFFFC;
  localparam logic [15:0] DST_NO_MEM = 16'hFFFB;
  localparam int DESC_TERM_BIT = 0;

  // ----------------------------------------------------------------
  // software registers over apb
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_PORT_B3 = 12'h004;
  localparam logic [11:0] REG_PORT_W = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;
  localparam logic [11:0] REG_OUT_CMD = 12'h010;
  localparam logic [11:0] REG_OUT_W = 12'h014;
  localparam int CTRL_GO_BIT = 8;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_CHK_FREE = 4'h1,
    S_WR_REQ = 4'h2,
    S_POLL_GRANT = 4'h3,
    S_WR_B3 = 4'h4,
    S_WR_W4 = 4'h5,
    S_WR_W6 = 4'h6,
    S_WR_CLR = 4'h7,
    S_POLL_DONE = 4'h8,
    S_OUT_RD2 = 4'h9,
    S_OUT_RD4 = 4'hA,
    S_OUT_RD6 = 4'hB,
    S_OUT_ACK = 4'hC
  } mbox_state_type;

endpackage

// ### dev_mailbox_model.sv
// behavioural model of the device's four-register command mailbox
`timescale 1ns/100ps
`default_nettype none
module dev_mailbox_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // device register bus
  input wire logic [2:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] pwdata_i,
  input wire logic [1:0] pstrb_i,
  output logic [15:0] prdata_o,
  output logic pready_o,
  // bench controls and views
  input wire logic [1:0] stall_i,
  input wire logic [10:0] grant_dly_i,
  input wire logic post_i,
  input wire logic [2:0] post_cmd_i,
  input wire logic [39:0] post_data_i,
  output logic [7:0] in_ctl_o,
  output logic [7:0] out_ctl_o,
  output logic [42:0] exec_o,
  output logic [7:0] in_irq_o,
  output logic [7:0] out_irq_o
);
  logic [7:0] mem [8];
  logic [1:0] wait_q;
  logic [15:0] last_q;
  logic [10:0] gcnt_q;
  logic [2:0] xcnt_q;
  logic [2:0] a;
  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  // word at an even byte, either lane alone or both
  assign a = {paddr_i[2:1], 1'b0};
  assign pready_o = psel_i & penable_i & (wait_q == 2'h0);
  // outside a completed access the data shows the inverse, so stale data never passes
  assign prdata_o = pready_o ? {mem[a + 3'h1], mem[a]} : ~last_q;
  assign in_ctl_o = mem[0];
  assign out_ctl_o = mem[2];
  // ----------------------------------------------------------------
  // device side of the handshakes
  // ----------------------------------------------------------------
  // grant latency is shortened to keep runs brief
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) mem[i] <= 8'h00;
      wait_q <= 2'h0;
      last_q <= 16'h0000;
      gcnt_q <= 11'h000;
      xcnt_q <= 3'h0;
      exec_o <= '0;
      in_irq_o <= 8'h00;
      out_irq_o <= 8'h00;
    end else begin
      if (psel_i && !penable_i) wait_q <= stall_i;
      else if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
      // grant flag belongs to the device, host writes leave it alone
      if (pready_o) begin
        last_q <= prdata_o;
        if (pwrite_i && pstrb_i[0]) mem[a] <= (a == 3'h0) ?
          {mem[0][7], pwdata_i[6:0]} : pwdata_i[7:0];
        if (pwrite_i && pstrb_i[1]) mem[a + 3'h1] <= pwdata_i[15:8];
      end
      if (mem[0][5] && !mem[0][7]) begin
        gcnt_q <= gcnt_q + 11'h001;
        // slow grants drop the enable briefly, which the host must notice and restore
        if (gcnt_q == 11'h001 && grant_dly_i > 11'h040) mem[0][6] <= 1'b0;
        if (gcnt_q == grant_dly_i) begin
          mem[0][7] <= 1'b1;
          gcnt_q <= 11'h000;
          in_irq_o <= in_irq_o + {7'h00, mem[0][6]};
        end
      end
      // request cleared while granted: take the command, finish a little later
      if (mem[0][7] && !mem[0][5]) begin
        xcnt_q <= xcnt_q + 3'h1;
        // direction sits at bit 3, bit 2 is unused
        if (xcnt_q == 3'h0) exec_o <= {mem[0][3], mem[0][1:0], mem[7], mem[6], mem[5], mem[4],
          mem[3]};
        if (xcnt_q == 3'h4) begin
          mem[0] <= mem[0] & 8'h40;
          xcnt_q <= 3'h0;
        end
      end
      if (post_i) begin
        mem[2] <= {1'b1, mem[2][6], 1'b1, 2'b00, post_cmd_i};
        {mem[7], mem[6], mem[5], mem[4], mem[3]} <= post_data_i;
        out_irq_o <= out_irq_o + {7'h00, mem[2][6]};
      end
    end
  end
endmodule
`default_nettype wire

// ### host_command_mailbox_bench.sv
// self-checking bench for the host-side command mailbox controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module host_command_mailbox_bench;
  import host_mailbox_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [2:0] dev_paddr_o;
  logic dev_psel_o;
  logic dev_penable_o;
  logic dev_pwrite_o;
  logic [15:0] dev_pwdata_o;
  logic [1:0] dev_pstrb_o;
  logic [15:0] dev_prdata;
  logic dev_pready;
  logic [1:0] stall = 2'h0;
  logic [10:0] grant_dly = 11'h002;
  logic post = 1'b0;
  logic [2:0] post_cmd = 3'h0;
  logic [39:0] post_data = 40'h0;
  logic [7:0] in_ctl;
  logic [7:0] out_ctl;
  logic [42:0] exec;
  logic [7:0] in_irq;
  logic [7:0] out_irq;
  int error_cnt = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic er;
  logic dir;
  logic ie;
  logic [1:0] ty;
  logic [7:0] b3;
  logic [7:0] irq0;
  logic [31:0] pw;
  logic [39:0] pd;
  logic [42:0] exp_q [$];
  logic [42:0] ex;
  logic oie = 1'b0;
  logic po;
  logic [1:0] in_types [3] = '{CMD_BD_IN, CMD_CTL_IN, CMD_LINE_INIT};
  logic [1:0] out_types [3] = '{CMD_BD_OUT, CMD_CTL_OUT, CMD_BUF_OUT};
  // ----------------------------------------------------------------
  // clock, design and device model
  // ----------------------------------------------------------------
  always #4 clk_i = ~clk_i;
  host_command_mailbox #(.GRANT_WAIT_CYC(200)) i_host_command_mailbox (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .dev_paddr_o(dev_paddr_o),
    .dev_psel_o(dev_psel_o), .dev_penable_o(dev_penable_o), .dev_pwrite_o(dev_pwrite_o),
    .dev_pwdata_o(dev_pwdata_o), .dev_pstrb_o(dev_pstrb_o), .dev_prdata_i(dev_prdata),
    .dev_pready_i(dev_pready));
  dev_mailbox_model i_dev_mailbox_model (
    .clk_i(clk_i), .rst_i(sys_rst_i), .paddr_i(dev_paddr_o), .psel_i(dev_psel_o),
    .penable_i(dev_penable_o), .pwrite_i(dev_pwrite_o), .pwdata_i(dev_pwdata_o),
    .pstrb_i(dev_pstrb_o), .prdata_o(dev_prdata), .pready_o(dev_pready), .stall_i(stall),
    .grant_dly_i(grant_dly), .post_i(post), .post_cmd_i(post_cmd), .post_data_i(post_data),
    .in_ctl_o(in_ctl), .out_ctl_o(out_ctl), .exec_o(exec), .in_irq_o(in_irq),
    .out_irq_o(out_irq));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one apb transfer, held until pready is seen, with a bounded wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic ok;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // slave outputs are flops: the mid-cycle value is what the next rising edge sees
    do begin
      @(negedge clk_i);
      ok = pready_o;
      rd = prdata_o;
      er = pslverr_o;
      @(posedge clk_i);
      n++;
    end while (ok !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input logic [11:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rd[b] !== v && n < 3000);
    if (n >= 3000) begin
      error_cnt++;
      conclude();
    end
  endtask
  task automatic do_reset;
    sys_rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    `CHK("pready in reset", 1'b0, pready_o)
    `CHK("device select in reset", 1'b0, dev_psel_o)
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(96));
    do_reset();
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK("status after reset", 32'h0, rd)
    apb(1'b0, 12'h0FC, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    `CHK("descriptor layout", {3'h0, 3'h2, 3'h4, 3'h6, 32'h0}, {DESC_ADDR_LO, DESC_ADDR_HI, DESC_WCOUNT, DESC_STATUS, DESC_TERM_BIT})
    `CHK("descriptor status codes", {16'h0001, 16'h0002, 16'hFFFC, 16'hFFFB}, {DST_COUNT_DONE, DST_RX_EOM, DST_READY_ERR, DST_NO_MEM})
    // grant that never comes: the wait gives up, then a second reset clears all
    grant_dly <= 11'h7D0;
    apb(1'b1, REG_CTRL, 32'h0000_0100);
    poll(REG_STATUS, 1, 1'b1);
    `CHK("no grant seen", 1'b0, in_ctl[7])
    do_reset();
    // every input command type, random direction, enable and port data
    for (int k = 0; k < 9; k++) begin
      ty = in_types[k % 3];
      dir = 1'($urandom);
      ie = 1'($urandom);
      b3 = 8'($urandom);
      pw = $urandom;
      stall <= 2'($urandom);
      grant_dly <= 11'(2 + $urandom % 150);
      irq0 = in_irq;
      exp_q.push_back({dir, ty, pw, b3});
      apb(1'b1, REG_PORT_B3, {24'h0, b3});
      apb(1'b1, REG_PORT_W, pw);
      apb(1'b1, REG_CTRL, {23'h0, 1'b1, 4'h0, ie, dir, ty});
      apb(1'b1, REG_PORT_B3, {24'h0, ~b3});
      poll(REG_CTRL, 8, 1'b0);
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK("input done", 1'b1, rd[0])
      apb(1'b1, REG_STATUS, 32'h1);
      ex = exp_q.pop_front();
      `CHK("executed command", ex, exec)
      `CHK("input byte after completion", {1'b0, ie, 6'h00}, in_ctl)
      `CHK("input interrupts", irq0 + {7'h00, ie}, in_irq)
    end
    // every output command type posted by the device
    for (int k = 0; k < 6; k++) begin
      ty = out_types[k % 3];
      dir = 1'($urandom);
      pd = {8'($urandom), $urandom};
      // the enable left by the last acknowledge is what the device sees at posting
      po = oie;
      oie = 1'($urandom);
      irq0 = out_irq;
      apb(1'b1, REG_CTRL, {27'h0, oie, 4'h0});
      @(posedge clk_i);
      post <= 1'b1;
      post_cmd <= {dir, ty};
      post_data <= pd;
      @(posedge clk_i);
      post <= 1'b0;
      poll(REG_STATUS, 2, 1'b1);
      `CHK("output interrupts", irq0 + {7'h00, po}, out_irq)
      apb(1'b0, REG_OUT_CMD, 32'h0);
      `CHK("output byte and byte3", {pd[7:0], 1'b1, po, 3'b100, dir, ty}, rd[15:0])
      apb(1'b0, REG_OUT_W, 32'h0);
      `CHK("output port words", pd[39:8], rd)
      `CHK("output byte released", {1'b0, oie, 6'h00}, out_ctl)
      apb(1'b1, REG_STATUS, 32'h4);
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK("output status cleared", 1'b0, rd[2])
    end
    conclude();
  end
endmodule
`default_nettype wire
